// ===== charger_regs_pkg.sv
// Purpose: Shared constants and carrier types for the charger configuration and status register bank.
// Assumes: Byte-wide registers at the printed offsets, accessed one byte per request.
// Notes:   The live status struct is laid out so that its packed value is the status byte.
package charger_regs_pkg;

    localparam logic [7:0] OFS_SETUP      = 8'h04;
    localparam logic [7:0] OFS_ADAPTER    = 8'h05;
    localparam logic [7:0] OFS_RESTART    = 8'h07;
    localparam logic [7:0] OFS_STATUS     = 8'h10;

    localparam logic [7:0] RST_SETUP      = 8'h89;
    localparam logic [7:0] RST_ADAPTER    = 8'h04;
    localparam logic [7:0] RST_RESTART    = 8'h01;
    localparam logic [7:0] RD_UNMAPPED    = 8'h00;

    // Writable bits of the adapter control register; bits 4 and 3 are live inputs.
    localparam logic [7:0] ADAPTER_RW_MASK = 8'hE7;

    localparam int AUX_OFF_BIT  = 6;
    localparam int DETECT_BIT   = 4;
    localparam int INHIBIT_BIT  = 3;
    localparam int FAST_SEL_LSB = 4;
    localparam int END_SEL_LSB  = 0;
    localparam int HOLD_SEL_LSB = 0;
    localparam int RESTART_LSB  = 0;
    localparam int SEL3_W       = 3;
    localparam int SEL2_W       = 2;

    // Bit 7 down to bit 0 of the live status register.
    typedef struct packed {
        logic endCurrentCompare;
        logic batteryShortCompare;
        logic tricklePathActive;
        logic dieHot;
        logic chargeLoopInactive;
        logic inputLimitInactive;
        logic busValid;
        logic voltageHoldPhase;
    } live_status_t;

    typedef struct packed {
        live_status_t live;
        logic         dedicatedAdapterDetected;
        logic         inhibitPin;
        logic         smallPackage;
    } pin_in_t;

    typedef struct packed {
        logic       write;
        logic [7:0] addr;
        logic [7:0] wrData;
    } link_req_t;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b01,
        LINK_WAIT = 2'b10
    } link_phase_t;

    typedef struct packed {
        link_phase_t phase;
        logic        reqTgl;
        link_req_t   req;
        logic        busy;
        logic        rdValid;
        logic [7:0]  rdData;
    } link_state_t;

    typedef struct packed {
        logic [7:0] setup;
        logic [7:0] adapter;
        logic [7:0] restart;
        logic       reqPrev;
        logic       ackTgl;
        logic [7:0] rdData;
        logic       terminate;
    } regs_state_t;

endpackage : charger_regs_pkg

// ===== sync_bits.sv
// Purpose: Two-flop synchroniser for a group of levels entering a clock domain.
// Assumes: Each bit is an independent level; no bit relation is kept across the crossing.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
module sync_bits #(
    parameter int W = 1
) (
    input  wire logic         clk,    // Destination clock.
    input  wire logic         rst_n,  // Synchronous reset, active low.
    input  wire logic [W-1:0] d,      // Asynchronous levels.
    output logic      [W-1:0] q       // Synchronised levels.
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    always_comb
    begin
        s_d.meta   = d;
        s_d.stable = s_q.meta;
        if (!rst_n)
        begin
            s_d = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        s_q <= s_d;
    end

    assign q = s_q.stable;

endmodule : sync_bits

// ===== link_port.sv
// Purpose: Link-clock front end that hands single register accesses to the control domain.
// Assumes: The control domain answers each request toggle with one acknowledge toggle.
// Notes:   Request fields stay frozen from the toggle until the acknowledge returns.
`timescale 1ns/1ps
module link_port
    import charger_regs_pkg::*;
(
    input  wire logic                        linkClk,    // Link clock.
    input  wire logic                        linkRst_n,  // Link reset, synchronous, active low.
    input  wire logic                        reqValid,   // One-cycle request strobe.
    input  wire charger_regs_pkg::link_req_t reqIn,      // Request fields.
    input  wire logic                        ackTglIn,   // Acknowledge toggle from control domain.
    input  wire logic [7:0]                  rdDataIn,   // Read data, stable once acknowledged.
    output logic                             busy,       // Request in flight.
    output logic                             rdValid,    // One-cycle completion strobe.
    output logic [7:0]                       rdData,     // Read data of the last access.
    output logic                             reqTgl,     // Request toggle to control domain.
    output charger_regs_pkg::link_req_t      reqHeld     // Frozen request fields.
);
    link_state_t s_q;
    link_state_t s_d;
    logic        ackSync;

    sync_bits #(.W(1)) u_ack_sync (
        .clk   (linkClk),
        .rst_n (linkRst_n),
        .d     (ackTglIn),
        .q     (ackSync)
    );

    always_comb
    begin
        s_d         = s_q;
        s_d.rdValid = 1'b0;
        case (s_q.phase)
            LINK_IDLE:
            begin
                // Strobes arriving while busy are dropped, so the held fields never move mid-crossing.
                if (reqValid)
                begin
                    s_d.req    = reqIn;
                    s_d.reqTgl = ~s_q.reqTgl;
                    s_d.busy   = 1'b1;
                    s_d.phase  = LINK_WAIT;
                end
            end
            LINK_WAIT:
            begin
                if (ackSync == s_q.reqTgl)
                begin
                    s_d.rdData  = rdDataIn;
                    s_d.rdValid = 1'b1;
                    s_d.busy    = 1'b0;
                    s_d.phase   = LINK_IDLE;
                end
            end
            default:
            begin
                s_d.phase = LINK_IDLE;
                s_d.busy  = 1'b0;
            end
        endcase
        if (!linkRst_n)
        begin
            s_d       = '0;
            s_d.phase = LINK_IDLE;
        end
    end

    always_ff @(posedge linkClk)
    begin
        s_q <= s_d;
    end

    assign busy    = s_q.busy;
    assign rdValid = s_q.rdValid;
    assign rdData  = s_q.rdData;
    assign reqTgl  = s_q.reqTgl;
    assign reqHeld = s_q.req;

endmodule : link_port

// ===== charger_config_status_regs.sv
// Purpose: Upper register bank of a charger: current selects, adapter control, recharge threshold, live status.
// Assumes: Serial engine delivers byte accesses on linkClk; analog flags are asynchronous levels.
// Notes:   Accesses cross by toggle handshake; the control side performs them on ref_clk.
// How it works
// - Charge-current setup register at 0x04 resets to 89h.
// - Adapter bit 6 turns auxiliary regulator off; reset depends on package.
// - Adapter bit 4 reads 1 while dedicated adapter holds input voltage.
// - Recharge threshold register at 0x07 resets 01h; 50 to 200 mV.
// - Live status at 0x10 is read-only, meaningful only in charge mode.
// - Status bit 7 is 1 when current below termination threshold.
// - Status bit 6 is 1 when battery above short threshold.
// - Status bit 5 is 1 while trickle pre-charge path enabled.
// - Status bit 4 is 1 when die above 120 degrees.
// - Status bit 3 is 1 when charge-current loop not in control.
// - Status bit 2 is 1 when input limit not restricting current.
// - Status bit 0 is 1 in constant-voltage phase.
// - Current-based termination happens only while termination enable is 1.
`timescale 1ns/1ps
module charger_config_status_regs (
    input  wire logic                        ref_clk,              // Control clock, 10 MHz.
    input  wire logic                        rst_n,                // Synchronous reset, active low.
    input  wire logic                        linkClk,              // Serial engine clock.
    input  wire logic                        linkRst_n,            // Link reset, synchronous, active low.
    input  wire logic                        linkReqValid,         // One-cycle access strobe.
    input  wire charger_regs_pkg::link_req_t linkReq,              // Access fields.
    output logic                             linkBusy,             // Access in flight.
    output logic                             linkRdValid,          // One-cycle completion strobe.
    output logic [7:0]                       linkRdData,           // Read data.
    input  wire charger_regs_pkg::pin_in_t   livePins,             // Asynchronous analog flags and strap.
    input  wire logic                        chargeMode,           // Device in charge mode.
    input  wire logic                        endOfChargeAllowed,   // Termination enable bit.
    output logic [2:0]                       fastCurrentSenseSel,  // Fast-charge sense code.
    output logic [2:0]                       endCurrentSenseSel,   // End-of-charge sense code.
    output logic                             auxRegulatorOff,      // Auxiliary regulator off.
    output logic [2:0]                       adapterHoldVoltageSel,// Adapter hold-voltage code.
    output logic [1:0]                       restartThresholdSel,  // Recharge threshold code.
    output logic                             terminateCharge       // Request to end charge.
);
    import charger_regs_pkg::*;

    regs_state_t s_q;
    regs_state_t s_d;
    pin_in_t     pinsSync;
    logic        reqTgl;
    logic        reqSync;
    link_req_t   reqHeld;
    logic        accessHit;
    logic [7:0]  statusByte;

    // Read decode of the whole map, with live bits merged in.
    function automatic logic [7:0] readMap(
        input logic [7:0]   addr,
        input regs_state_t  st,
        input pin_in_t      pins,
        input logic         inCharge
    );
        logic [7:0] adapterView;
        adapterView              = st.adapter & ADAPTER_RW_MASK;
        adapterView[DETECT_BIT]  = pins.dedicatedAdapterDetected;
        adapterView[INHIBIT_BIT] = pins.inhibitPin;
        case (addr)
            OFS_SETUP:   readMap = st.setup;
            OFS_ADAPTER: readMap = adapterView;
            OFS_RESTART: readMap = st.restart;
            // Outside charge mode the comparators mean nothing, so the register reads zero.
            OFS_STATUS:  readMap = inCharge ? pins.live : RD_UNMAPPED;
            default:     readMap = RD_UNMAPPED;
        endcase
    endfunction : readMap

    link_port u_link (
        .linkClk   (linkClk),
        .linkRst_n (linkRst_n),
        .reqValid  (linkReqValid),
        .reqIn     (linkReq),
        .ackTglIn  (s_q.ackTgl),
        .rdDataIn  (s_q.rdData),
        .busy      (linkBusy),
        .rdValid   (linkRdValid),
        .rdData    (linkRdData),
        .reqTgl    (reqTgl),
        .reqHeld   (reqHeld)
    );

    sync_bits #(.W(1)) u_req_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .d     (reqTgl),
        .q     (reqSync)
    );

    // The package strap is captured by the reset branch, so this synchroniser keeps running through reset.
    sync_bits #(.W($bits(pin_in_t))) u_pin_sync (
        .clk   (ref_clk),
        .rst_n (1'b1),
        .d     (livePins),
        .q     (pinsSync)
    );

    // Each status bit is the synchronised comparator of the same position.
    assign statusByte = {pinsSync.live.endCurrentCompare,
                         pinsSync.live.batteryShortCompare,
                         pinsSync.live.tricklePathActive,
                         pinsSync.live.dieHot,
                         pinsSync.live.chargeLoopInactive,
                         pinsSync.live.inputLimitInactive,
                         pinsSync.live.busValid,
                         pinsSync.live.voltageHoldPhase};

    assign accessHit = reqSync != s_q.reqPrev;

    always_comb
    begin
        s_d         = s_q;
        s_d.reqPrev = reqSync;
        // Termination on the end-of-charge comparator is blocked while the enable is clear.
        s_d.terminate = endOfChargeAllowed & chargeMode & pinsSync.live.endCurrentCompare;
        if (accessHit)
        begin
            s_d.ackTgl = ~s_q.ackTgl;
            s_d.rdData = readMap(reqHeld.addr, s_q, pinsSync, chargeMode);
            if (reqHeld.write)
            begin
                case (reqHeld.addr)
                    OFS_SETUP:   s_d.setup   = reqHeld.wrData;
                    OFS_ADAPTER: s_d.adapter = reqHeld.wrData & ADAPTER_RW_MASK;
                    OFS_RESTART: s_d.restart = reqHeld.wrData;
                    default:     s_d.setup   = s_q.setup;
                endcase
            end
        end
        if (!rst_n)
        begin
            s_d                      = '0;
            s_d.setup                = RST_SETUP;
            s_d.adapter              = RST_ADAPTER;
            s_d.adapter[AUX_OFF_BIT] = pinsSync.smallPackage;
            s_d.restart              = RST_RESTART;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        s_q <= s_d;
    end

    assign fastCurrentSenseSel   = s_q.setup[FAST_SEL_LSB +: SEL3_W];
    assign endCurrentSenseSel    = s_q.setup[END_SEL_LSB +: SEL3_W];
    assign auxRegulatorOff       = s_q.adapter[AUX_OFF_BIT];
    assign adapterHoldVoltageSel = s_q.adapter[HOLD_SEL_LSB +: SEL3_W];
    assign restartThresholdSel   = s_q.restart[RESTART_LSB +: SEL2_W];
    assign terminateCharge       = s_q.terminate;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_setup_reset: assert property ($past(!rst_n) |-> s_q.setup == 8'h89)
        else $error("setup register not 89h after reset");

    a_sense_write: assert property (accessHit && reqHeld.write && reqHeld.addr == 8'h04 |=>
        fastCurrentSenseSel == $past(reqHeld.wrData[6:4]) && endCurrentSenseSel == $past(reqHeld.wrData[2:0]))
        else $error("sense selects did not follow the write");

    a_aux_strap: assert property ($past(!rst_n) |-> auxRegulatorOff == $past(pinsSync.smallPackage))
        else $error("regulator off bit wrong after reset");

    a_adapter_read: assert property (accessHit && !reqHeld.write && reqHeld.addr == 8'h05 |=>
        s_q.rdData[4] == $past(pinsSync.dedicatedAdapterDetected) && s_q.rdData[3] == $past(pinsSync.inhibitPin))
        else $error("adapter live bits read wrong");

    a_hold_reset: assert property ($past(!rst_n) |-> adapterHoldVoltageSel == 3'h4 && s_q.adapter[7] == 1'b0)
        else $error("hold voltage select not 100 after reset");

    a_restart_reset: assert property ($past(!rst_n) |-> s_q.restart == 8'h01 && restartThresholdSel == 2'h1)
        else $error("restart threshold not 01h after reset");

    a_status_read: assert property (accessHit && reqHeld.addr == 8'h10 && chargeMode |=>
        s_q.rdData == $past(statusByte))
        else $error("live status read does not match comparators");

    a_status_idle: assert property (accessHit && reqHeld.addr == 8'h10 && !chargeMode |=> s_q.rdData == 8'h00)
        else $error("live status not zero outside charge mode");

    a_term_gate: assert property (terminateCharge |-> $past(endOfChargeAllowed) && $past(chargeMode))
        else $error("termination without enable");

    a_ro_write: assert property (accessHit && reqHeld.write && reqHeld.addr == 8'h10 |=>
        $stable(s_q.setup) && $stable(s_q.adapter) && $stable(s_q.restart))
        else $error("write to status register changed storage");

    a_ack_once: assert property (accessHit |=> s_q.ackTgl != $past(s_q.ackTgl) ##1 s_q.ackTgl == $past(s_q.ackTgl))
        else $error("acknowledge toggle not single");

    c_setup_write: cover property (accessHit && reqHeld.write && reqHeld.addr == 8'h04);
    c_status_read: cover property (accessHit && !reqHeld.write && reqHeld.addr == 8'h10 && chargeMode);
    c_terminate:   cover property ($rose(terminateCharge));
    c_aux_on:      cover property ($fell(auxRegulatorOff));

endmodule : charger_config_status_regs

// ===== link_host_model.sv
// Purpose: Serial engine stand-in that issues single byte accesses on the link side.
// Assumes: One access at a time; strobe lasts one linkClk cycle.
// Notes:   Released request fields show the inverse of their last value.
`timescale 1ns/1ps
module link_host_model (
    input  wire logic                   linkClk,      // Link clock.
    input  wire logic                   linkBusy,     // Access in flight.
    input  wire logic                   linkRdValid,  // Completion strobe.
    input  wire logic [7:0]             linkRdData,   // Read data.
    output logic                        linkReqValid, // Access strobe.
    output charger_regs_pkg::link_req_t linkReq       // Access fields.
);
    import charger_regs_pkg::*;

    logic busySeen;

    initial
    begin
        linkReqValid = 1'b0;
        linkReq = '0;
        busySeen = 1'b0;
    end

    // With extra set, a second strobe is sent while busy; it must be dropped.
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          input logic extra, output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge linkClk);
        #1;
        linkReqValid = 1'b1;
        linkReq = '{write: w, addr: a, wrData: d};
        @(posedge linkClk);
        #1;
        busySeen = linkBusy;
        linkReqValid = extra;
        linkReq = extra ? '{write: 1'b1, addr: a, wrData: ~d} : ~linkReq;
        if (extra)
        begin
            @(posedge linkClk);
            #1;
            linkReqValid = 1'b0;
            linkReq = ~linkReq;
        end
        do
        begin
            @(posedge linkClk);
            #1;
            n++;
        end
        while (linkRdValid !== 1'b1 && n < 200);
        rd = (n < 200) ? linkRdData : 8'hXX;
    endtask : access
endmodule : link_host_model

// ===== test_charger_config_status_regs.sv
// Purpose: Self-checking bench for the charger configuration and status register bank.
// Assumes: Link accesses come from the host model; analog flags are driven here.
// Notes:   A shadow array holds the expected read value of every offset.
`timescale 1ns/1ps
module test_charger_config_status_regs;
    import charger_regs_pkg::*;

    localparam int NROWS = 22;
    // Offset, written byte, expected read-back.
    localparam logic [23:0] ROWS [NROWS] = '{
        24'h040707, 24'h041616, 24'h04A5A5, 24'h043434, 24'h04C3C3, 24'h045252,
        24'h04E1E1, 24'h047070, 24'h051800, 24'h050101, 24'h054242, 24'h050303,
        24'h052424, 24'h050505, 24'h050606, 24'h05FFE7, 24'h070000, 24'h070202,
        24'h07FFFF, 24'h070101, 24'h065A00, 24'h10FF00};

    logic        ref_clk = 1'b0;
    logic        linkClk = 1'b0;
    logic        rst_n, linkRst_n, linkReqValid, linkBusy, linkRdValid;
    logic        chargeMode, endOfChargeAllowed, auxRegulatorOff, terminateCharge;
    logic [7:0]  linkRdData, rd;
    logic [2:0]  fastCurrentSenseSel, endCurrentSenseSel, adapterHoldVoltageSel;
    logic [1:0]  restartThresholdSel;
    link_req_t   linkReq;
    pin_in_t     livePins;
    logic [7:0]  shadow [256];
    int          errorCnt = 0;
    int          checksDone = 0;

    always #50 ref_clk = ~ref_clk;
    // The odd half period keeps link rising edges off the control rising edges.
    always #7.5 linkClk = ~linkClk;

    charger_config_status_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .linkClk(linkClk),
        .linkRst_n(linkRst_n), .linkReqValid(linkReqValid), .linkReq(linkReq),
        .linkBusy(linkBusy), .linkRdValid(linkRdValid), .linkRdData(linkRdData),
        .livePins(livePins), .chargeMode(chargeMode), .endOfChargeAllowed(endOfChargeAllowed),
        .fastCurrentSenseSel(fastCurrentSenseSel), .endCurrentSenseSel(endCurrentSenseSel),
        .auxRegulatorOff(auxRegulatorOff), .adapterHoldVoltageSel(adapterHoldVoltageSel),
        .restartThresholdSel(restartThresholdSel), .terminateCharge(terminateCharge));

    link_host_model i_host (.linkClk(linkClk), .linkBusy(linkBusy), .linkRdValid(linkRdValid),
        .linkRdData(linkRdData), .linkReqValid(linkReqValid), .linkReq(linkReq));

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checksDone++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] newVal);
        i_host.access(1'b1, a, d, 1'b0, rd);
        chk("write old value", shadow[a], rd);
        shadow[a] = newVal;
        settle(1);
    endtask : wr

    task automatic rdc(input logic [7:0] a);
        i_host.access(1'b0, a, 8'h00, 1'b0, rd);
        chk($sformatf("read %h", a), shadow[a], rd);
        chk("busy while in flight", 8'h01, {7'h00, i_host.busySeen});
        chk("busy after completion", 8'h00, {7'h00, linkBusy});
        settle(1);
    endtask : rdc

    task automatic chk_cfg();
        logic term;
        term = chargeMode & endOfChargeAllowed & livePins.live.endCurrentCompare;
        chk("fastSel", {5'h00, shadow[OFS_SETUP][6:4]}, {5'h00, fastCurrentSenseSel});
        chk("endSel", {5'h00, shadow[OFS_SETUP][2:0]}, {5'h00, endCurrentSenseSel});
        chk("auxOff", {7'h00, shadow[OFS_ADAPTER][6]}, {7'h00, auxRegulatorOff});
        chk("holdSel", {5'h00, shadow[OFS_ADAPTER][2:0]}, {5'h00, adapterHoldVoltageSel});
        chk("restartSel", {6'h00, shadow[OFS_RESTART][1:0]}, {6'h00, restartThresholdSel});
        chk("terminate", {7'h00, term}, {7'h00, terminateCharge});
    endtask : chk_cfg

    // Both domains are reset together; the strap is held steady across release.
    task automatic do_reset(input logic strap);
        settle(1);
        rst_n = 1'b0;
        linkRst_n = 1'b0;
        livePins = '0;
        livePins.smallPackage = strap;
        chargeMode = 1'b0;
        endOfChargeAllowed = 1'b0;
        foreach (shadow[i]) shadow[i] = 8'h00;
        shadow[OFS_SETUP] = 8'h89;
        shadow[OFS_ADAPTER] = strap ? 8'h44 : 8'h04;
        shadow[OFS_RESTART] = 8'h01;
        settle(10);
        rst_n = 1'b1;
        @(posedge linkClk);
        #1;
        linkRst_n = 1'b1;
        settle(4);
        chk_cfg();
        rdc(OFS_SETUP);
        rdc(OFS_ADAPTER);
        rdc(OFS_RESTART);
        $display("Test reset values done");
    endtask : do_reset

    initial
    begin
        rst_n = 1'b0;
        linkRst_n = 1'b0;
        livePins = '0;
        chargeMode = 1'b0;
        endOfChargeAllowed = 1'b0;
        do_reset(1'b0);
        for (int i = 0; i < NROWS; i++)
        begin
            wr(ROWS[i][23:16], ROWS[i][15:8], ROWS[i][7:0]);
            rdc(ROWS[i][23:16]);
            chk_cfg();
        end
        $display("Test table rows done");
        chargeMode = 1'b1;
        for (int b = 0; b < 8; b++)
        begin
            livePins.live = live_status_t'(8'h01 << b);
            shadow[OFS_STATUS] = 8'h01 << b;
            settle(4);
            rdc(OFS_STATUS);
        end
        livePins.live = '0;
        shadow[OFS_STATUS] = 8'h00;
        settle(4);
        wr(OFS_STATUS, 8'hFF, 8'h00);
        rdc(OFS_STATUS);
        livePins.live = live_status_t'(8'hFF);
        chargeMode = 1'b0;
        settle(4);
        rdc(OFS_STATUS);
        $display("Test live status done");
        livePins.live = '0;
        livePins.dedicatedAdapterDetected = 1'b1;
        shadow[OFS_ADAPTER] = shadow[OFS_ADAPTER] | 8'h10;
        settle(4);
        rdc(OFS_ADAPTER);
        livePins.dedicatedAdapterDetected = 1'b0;
        livePins.inhibitPin = 1'b1;
        shadow[OFS_ADAPTER] = (shadow[OFS_ADAPTER] & 8'hE7) | 8'h08;
        settle(4);
        wr(OFS_ADAPTER, 8'h02, 8'h0A);
        rdc(OFS_ADAPTER);
        $display("Test adapter status done");
        chargeMode = 1'b1;
        endOfChargeAllowed = 1'b1;
        livePins.live = live_status_t'(8'h80);
        settle(5);
        chk_cfg();
        endOfChargeAllowed = 1'b0;
        settle(3);
        chk_cfg();
        endOfChargeAllowed = 1'b1;
        chargeMode = 1'b0;
        settle(3);
        chk_cfg();
        $display("Test termination done");
        i_host.access(1'b1, OFS_RESTART, 8'h02, 1'b1, rd);
        chk("busy write old value", shadow[OFS_RESTART], rd);
        shadow[OFS_RESTART] = 8'h02;
        rdc(OFS_RESTART);
        chk_cfg();
        $display("Test strobe while busy done");
        do_reset(1'b1);
        $display("Test second reset done");
        end_of_test();
    end

    initial
    begin
        #500000;
        errorCnt++;
        $display("Error watchdog expected completion seen timeout");
        end_of_test();
    end
endmodule : test_charger_config_status_regs
